// [psr_fifo.sv]
`default_nettype none

module psr_fifo
#(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
)
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic in_valid,
  output var logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output var logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW:0] DEPTH_W = (AW+1)'(DEPTH);
  localparam logic [AW-1:0] LAST_W = AW'(DEPTH - 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] wr_ptr_next;
  logic [AW-1:0] rd_ptr_reg;
  logic [AW-1:0] rd_ptr_next;
  logic [AW:0] count_reg;
  logic [AW:0] count_next;
  logic push;
  logic pop;

  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem[rd_ptr_reg];

  always_comb
  begin
    wr_ptr_next = wr_ptr_reg;
    rd_ptr_next = rd_ptr_reg;
    count_next = count_reg;
    if (push)
    begin
      wr_ptr_next = (wr_ptr_reg == LAST_W) ? '0 : wr_ptr_reg + 1'b1;
    end
    if (pop)
    begin
      rd_ptr_next = (rd_ptr_reg == LAST_W) ? '0 : rd_ptr_reg + 1'b1;
    end
    if (push && !pop)
    begin
      count_next = count_reg + 1'b1;
    end
    else if (pop && !push)
    begin
      count_next = count_reg - 1'b1;
    end
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
      in_ready <= 1'b0;
      out_valid <= 1'b0;
    end
    else
    begin
      wr_ptr_reg <= wr_ptr_next;
      rd_ptr_reg <= rd_ptr_next;
      count_reg <= count_next;
      in_ready <= (count_next != DEPTH_W);
      out_valid <= (count_next != '0);
    end
  end

  always_ff @(posedge clk)
  begin
    if (push)
    begin
      mem[wr_ptr_reg] <= in_data;
    end
  end
endmodule : psr_fifo

`default_nettype wire

// [psr_readout.sv]
// Contract
// - Command bits are taken from the input on rising shift clock edges.
// - Output bits change on rising shift clock edges.
// - Output carries result or calibration data and also conversion status.
// - Seven commands: pressure, temperature, four calibration reads, reset.
// - Each of the six setup commands opens with three high start bits; the reset pattern opens 101.
// - Each command closes with three low stop bits.
// - A four bit setup field selects the data to read.
// - Conversion acknowledge raises output during the last stop bit.
// - Clock held low during conversion; output falls at completion.
// - Seventeen clocks after completion shift out the 16-bit result.
// - Readout may pause on a held clock and resumes at same bit.
// - The 21-bit reset pattern returns to idle from any state.
// - Pressure and temperature come back as raw 16-bit values.
// - Four 16-bit calibration words, read by four calibration commands.
// - One shared converter; sensing element powered only briefly.
`default_nettype none

package psr_pkg;
  localparam int WORD_W = 16;
  localparam int FIFO_DEPTH = 16;
  localparam int START_BITS = 3;
  localparam int SETUP_BITS = 4;
  localparam int STOP_BITS = 3;
  localparam int FRAME_BITS = START_BITS + SETUP_BITS + STOP_BITS;
  localparam int RESET_BITS = 21;
  localparam int ACK_CLOCKS = 2;
  localparam int READ_CLOCKS = 17;
  localparam logic [4:0] READ_LAST = 5'(READ_CLOCKS - 1);
  localparam logic [1:0] ACK_LAST = 2'(ACK_CLOCKS - 1);
  // Setup codes and reset pattern
  localparam logic [3:0] CODE_PRESS = 4'hC;
  localparam logic [3:0] CODE_TEMP = 4'hA;
  localparam logic [3:0] CODE_CAL1 = 4'h5;
  localparam logic [3:0] CODE_CAL3 = 4'h6;
  localparam logic [3:0] CODE_CAL2 = 4'h9;
  localparam logic [3:0] CODE_CAL4 = 4'h3;
  localparam logic [20:0] RESET_PATTERN = 21'h15_5540;
  localparam logic [15:0] CAL_WORD_RESET = 16'h0000;
  // Conversion timing in master clock ticks
  localparam int MCLK_HZ = 32768;
  localparam int CONV_TIME_US = 35000;
  localparam int ON_TIME_US = 2000;
  localparam int CONV_TICKS = int'((longint'(CONV_TIME_US) * MCLK_HZ)
    / 1000000);
  localparam int ON_TICKS = int'((longint'(ON_TIME_US) * MCLK_HZ)
    / 1000000);
  localparam logic [10:0] CONV_TICKS_W = 11'(CONV_TICKS);
  localparam logic [10:0] ON_TICKS_W = 11'(ON_TICKS);

  typedef enum logic [2:0] {
    PSR_IDLE,
    PSR_ACK,
    PSR_CONV,
    PSR_READ
  } psr_state_t;
endpackage : psr_pkg

module psr_readout
#(
  parameter logic [3:0] CODE_PRESS = psr_pkg::CODE_PRESS,
  parameter logic [3:0] CODE_TEMP = psr_pkg::CODE_TEMP,
  parameter logic [3:0] CODE_CAL1 = psr_pkg::CODE_CAL1,
  parameter logic [3:0] CODE_CAL3 = psr_pkg::CODE_CAL3,
  parameter logic [3:0] CODE_CAL2 = psr_pkg::CODE_CAL2,
  parameter logic [3:0] CODE_CAL4 = psr_pkg::CODE_CAL4,
  parameter logic [20:0] RESET_PATTERN = psr_pkg::RESET_PATTERN,
  parameter logic [15:0] CAL_CALIBRATION_WORD_FIRST = psr_pkg::CAL_WORD_RESET,
  parameter logic [15:0] CAL_WORD2 = psr_pkg::CAL_WORD_RESET,
  parameter logic [15:0] CAL_WORD3 = psr_pkg::CAL_WORD_RESET,
  parameter logic [15:0] CAL_CALIBRATION_WORD_LAST = psr_pkg::CAL_WORD_RESET,
  parameter int FIFO_DEPTH = psr_pkg::FIFO_DEPTH
)
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic sclk,
  input wire logic din,
  input wire logic mclk,
  output var logic dout,
  input wire logic adc_valid,
  input wire logic [15:0] adc_data,
  output var logic adc_ready,
  output var logic adc_channel,
  output var logic sensor_power
);
  logic sclk_s1, sclk_s2, sclk_s3;
  logic din_s1, din_s2;
  logic mclk_s1, mclk_s2, mclk_s3;
  logic sclk_rise, mclk_tick;

  psr_pkg::psr_state_t state_reg;
  psr_pkg::psr_state_t state_next;
  logic [9:0] win_reg;
  logic [9:0] win_next;
  logic [20:0] hist_reg;
  logic [20:0] hist_next;
  logic [15:0] word_reg;
  logic [15:0] word_next;
  logic [4:0] bit_cnt_reg;
  logic [4:0] bit_cnt_next;
  logic [1:0] ack_cnt_reg;
  logic [1:0] ack_cnt_next;
  logic [10:0] tick_reg;
  logic [10:0] tick_next;
  logic dout_next, chan_next, power_next;
  logic [9:0] win_shift;
  logic [20:0] hist_shift;
  logic frame_ok, reset_hit;
  logic [3:0] setup;
  logic fifo_valid;
  logic fifo_pop;
  logic [15:0] fifo_data;

  // Word queue from the shared converter
  psr_fifo #(
    .WIDTH(psr_pkg::WORD_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .nrst(nrst),
    .in_valid(adc_valid),
    .in_ready(adc_ready),
    .in_data(adc_data),
    .out_valid(fifo_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_data)
  );

  // Pin synchronisers and edge detection
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      {sclk_s1, sclk_s2, sclk_s3} <= '0;
      {din_s1, din_s2} <= '0;
      {mclk_s1, mclk_s2, mclk_s3} <= '0;
    end
    else
    begin
      {sclk_s3, sclk_s2, sclk_s1} <= {sclk_s2, sclk_s1, sclk};
      {din_s2, din_s1} <= {din_s1, din};
      {mclk_s3, mclk_s2, mclk_s1} <= {mclk_s2, mclk_s1, mclk};
    end
  end

  assign sclk_rise = sclk_s2 && !sclk_s3;
  assign mclk_tick = mclk_s2 && !mclk_s3;

  assign win_shift = {win_reg[8:0], din_s2};
  assign hist_shift = {hist_reg[19:0], din_s2};
  assign setup = win_shift[6:3];
  assign frame_ok = (win_shift[9:7] == 3'b111)
    && (win_shift[2:0] == 3'b000);
  assign reset_hit = sclk_rise && (hist_shift == RESET_PATTERN);

  always_comb
  begin
    state_next = state_reg;
    win_next = win_reg;
    hist_next = hist_reg;
    word_next = word_reg;
    bit_cnt_next = bit_cnt_reg;
    ack_cnt_next = ack_cnt_reg;
    tick_next = tick_reg;
    dout_next = dout;
    chan_next = adc_channel;
    power_next = 1'b0;
    fifo_pop = 1'b0;
    if (sclk_rise)
    begin
      hist_next = hist_shift;
    end
    if (reset_hit)
    begin
      // Any state back to idle
      state_next = psr_pkg::PSR_IDLE;
      hist_next = '0;
      win_next = '0;
      dout_next = 1'b0;
    end
    else
    begin
      case (state_reg)
        psr_pkg::PSR_IDLE:
        begin
          if (sclk_rise)
          begin
            win_next = win_shift;
            if (frame_ok)
            begin
              win_next = '0;
              bit_cnt_next = '0;
              ack_cnt_next = '0;
              tick_next = '0;
              // Decode the six setup commands
              if (setup == CODE_PRESS || setup == CODE_TEMP)
              begin
                chan_next = (setup == CODE_TEMP);
                dout_next = 1'b1;
                state_next = psr_pkg::PSR_ACK;
              end
              else if (setup == CODE_CAL1 || setup == CODE_CAL3
                || setup == CODE_CAL2 || setup == CODE_CAL4)
              begin
                word_next = (setup == CODE_CAL1) ? CAL_CALIBRATION_WORD_FIRST
                  : (setup == CODE_CAL3) ? CAL_WORD3
                  : (setup == CODE_CAL2) ? CAL_WORD2 : CAL_CALIBRATION_WORD_LAST;
                state_next = psr_pkg::PSR_READ;
              end
            end
          end
        end
        psr_pkg::PSR_ACK:
        begin
          // Two trailing clocks after acknowledge
          if (sclk_rise)
          begin
            ack_cnt_next = ack_cnt_reg + 2'd1;
            if (ack_cnt_reg == psr_pkg::ACK_LAST)
            begin
              state_next = psr_pkg::PSR_CONV;
            end
          end
        end
        psr_pkg::PSR_CONV:
        begin
          power_next = (tick_reg < psr_pkg::ON_TICKS_W);
          if (mclk_tick && tick_reg < psr_pkg::CONV_TICKS_W)
          begin
            tick_next = tick_reg + 11'd1;
          end
          if (tick_reg >= psr_pkg::CONV_TICKS_W && fifo_valid)
          begin
            fifo_pop = 1'b1;
            word_next = fifo_data;
            dout_next = 1'b0;
            power_next = 1'b0;
            state_next = psr_pkg::PSR_READ;
          end
        end
        psr_pkg::PSR_READ:
        begin
          // Held clock simply freezes the shift
          if (sclk_rise)
          begin
            bit_cnt_next = bit_cnt_reg + 5'd1;
            if (bit_cnt_reg == psr_pkg::READ_LAST)
            begin
              dout_next = 1'b0;
              state_next = psr_pkg::PSR_IDLE;
            end
            else
            begin
              dout_next = word_reg[15];
              word_next = {word_reg[14:0], 1'b0};
            end
          end
        end
        default:
        begin
          state_next = psr_pkg::PSR_IDLE;
          dout_next = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      state_reg <= psr_pkg::PSR_IDLE;
      win_reg <= '0;
      hist_reg <= '0;
      word_reg <= '0;
      bit_cnt_reg <= '0;
      ack_cnt_reg <= '0;
      tick_reg <= '0;
      dout <= 1'b0;
      adc_channel <= 1'b0;
      sensor_power <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      win_reg <= win_next;
      hist_reg <= hist_next;
      word_reg <= word_next;
      bit_cnt_reg <= bit_cnt_next;
      ack_cnt_reg <= ack_cnt_next;
      tick_reg <= tick_next;
      dout <= dout_next;
      adc_channel <= chan_next;
      sensor_power <= power_next;
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  a_capture_on_rise: assert property (
    !sclk_rise |=> $stable(win_reg) && $stable(hist_reg))
    else $error("command window moved without a shift clock rise");
  a_update_on_rise: assert property (
    $changed(dout) |-> $past(sclk_rise) || $past(state_reg)
      == psr_pkg::PSR_CONV)
    else $error("output changed off a rising shift clock edge");
  a_ack_raise: assert property (
    state_reg == psr_pkg::PSR_IDLE && !reset_hit && sclk_rise
      && frame_ok && (setup == CODE_PRESS || setup == CODE_TEMP)
      |=> dout && state_reg == psr_pkg::PSR_ACK)
    else $error("conversion start not acknowledged");
  a_conv_high: assert property (
    state_reg == psr_pkg::PSR_CONV |-> dout)
    else $error("output low during conversion");
  a_done_fall: assert property (
    state_reg == psr_pkg::PSR_CONV
      && state_next == psr_pkg::PSR_READ |=> !dout && bit_cnt_reg == 0)
    else $error("completion not marked by a falling output");
  a_msb_first: assert property (
    state_reg == psr_pkg::PSR_READ && sclk_rise && !reset_hit
      && bit_cnt_reg != psr_pkg::READ_LAST |=> dout == $past(word_reg[15]))
    else $error("readout bit out of order");
  a_read_len: assert property (
    state_reg == psr_pkg::PSR_READ && sclk_rise
      && bit_cnt_reg == psr_pkg::READ_LAST |=> state_reg
      == psr_pkg::PSR_IDLE && !dout)
    else $error("readout did not end after seventeen clocks");
  a_pause_hold: assert property (
    state_reg == psr_pkg::PSR_READ && !sclk_rise |=> $stable(dout)
      && $stable(bit_cnt_reg) && $stable(word_reg))
    else $error("readout advanced while clock held");
  a_reset_any: assert property (
    reset_hit |=> state_reg == psr_pkg::PSR_IDLE && hist_reg == 0)
    else $error("reset pattern did not return to idle");
  a_power_brief: assert property (
    sensor_power |-> $past(state_reg) == psr_pkg::PSR_CONV
      && $past(tick_reg) < psr_pkg::ON_TICKS_W)
    else $error("sensing element powered outside its window");
  a_two_acks: assert property (
    state_reg == psr_pkg::PSR_ACK && sclk_rise && !reset_hit
      && ack_cnt_reg == psr_pkg::ACK_LAST |=> state_reg
      == psr_pkg::PSR_CONV)
    else $error("conversion did not start after two clocks");

  c_conv_done: cover property (
    state_reg == psr_pkg::PSR_CONV ##1 state_reg == psr_pkg::PSR_READ);
  c_cal_read: cover property (
    state_reg == psr_pkg::PSR_IDLE ##1 state_reg == psr_pkg::PSR_READ);
  c_reset_seen: cover property (
    reset_hit && state_reg != psr_pkg::PSR_IDLE);
  c_read_pause: cover property (
    (state_reg == psr_pkg::PSR_READ && !sclk_rise) [*8]);
endmodule : psr_readout

`default_nettype wire

// [psr_host.sv]
`default_nettype none

module psr_host
(
  input wire logic clk,
  input wire logic dout,
  output var logic sclk,
  output var logic din
);
  timeunit 1ns;
  timeprecision 1ps;

  initial
  begin
    sclk = 1'b0;
    din = 1'b0;
  end

  task automatic wclk(input int n);
    repeat (n) @(posedge clk);
    #5;
  endtask : wclk

  // Half period of 20 cycles keeps the shift clock at 500 kHz
  task automatic xbit(input logic b, output logic q);
    din = b;
    wclk(20);
    sclk = 1'b1;
    wclk(20);
    q = dout;
    sclk = 1'b0;
  endtask : xbit

  task automatic frame(input logic [3:0] code, output logic [9:0] seen);
    logic [9:0] bits;
    bits = {3'b111, code, 3'b000};
    for (int i = 9; i >= 0; i--)
    begin
      xbit(bits[i], seen[i]);
    end
  endtask : frame

  task automatic ack2(output logic q);
    xbit(1'b0, q);
    xbit(1'b0, q);
  endtask : ack2

  // Optional hold of the shift clock in mid-word
  task automatic read17(input logic pause, output logic [16:0] seen);
    for (int i = 16; i >= 0; i--)
    begin
      xbit(1'b0, seen[i]);
      if (pause && i == 9)
      begin
        wclk(200);
      end
    end
  endtask : read17

  // Output is ignored while the pattern goes out
  task automatic sendrst();
    logic q;
    for (int i = 20; i >= 0; i--)
    begin
      xbit(psr_pkg::RESET_PATTERN[i], q);
    end
  endtask : sendrst
endmodule : psr_host

`default_nettype wire

// [test_pressure_sensor_serial_readout.sv]
`default_nettype none

module test_pressure_sensor_serial_readout;
  timeunit 1ns;
  timeprecision 1ps;

  localparam logic [15:0] W1 = 16'h1A2B;
  localparam logic [15:0] W2 = 16'h3C4D;
  localparam logic [15:0] W3 = 16'h5E6F;
  localparam logic [15:0] W4 = 16'h7081;

  logic clk, nrst, sclk, din, mclk, dout;
  logic adc_valid, adc_ready, adc_channel, sensor_power, mclk_run;
  logic [15:0] adc_data;
  int failures, n_compared;

  psr_readout #(.CAL_CALIBRATION_WORD_FIRST(W1), .CAL_WORD2(W2), .CAL_WORD3(W3),
    .CAL_CALIBRATION_WORD_LAST(W4)) dut (.clk(clk), .nrst(nrst), .sclk(sclk),
    .din(din), .mclk(mclk), .dout(dout), .adc_valid(adc_valid),
    .adc_data(adc_data), .adc_ready(adc_ready),
    .adc_channel(adc_channel), .sensor_power(sensor_power));

  psr_host host (.clk(clk), .dout(dout), .sclk(sclk), .din(din));

  always #25 clk = ~clk;

  // Fast master clock keeps each conversion short; stopped during the calibration reads of t_cal
  always
  begin
    @(posedge clk);
    #5;
    if (mclk_run)
    begin
      mclk = ~mclk;
    end
  end

  task automatic summarize();
    if (failures == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : summarize

  task automatic chk(input string what, input logic [15:0] exp,
    input logic [15:0] got);
    n_compared++;
    if (got !== exp)
    begin
      failures++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic push(input logic [15:0] w);
    logic ok;
    ok = 1'b0;
    adc_data = w;
    adc_valid = 1'b1;
    for (int i = 0; i < 100 && !ok; i++)
    begin
      @(posedge clk);
      ok = (adc_ready === 1'b1);
    end
    #5;
    if (!ok)
    begin
      failures++;
      summarize();
    end
  endtask : push

  task automatic conv(input logic [3:0] code, input logic chan,
    input logic [15:0] w, input logic pause);
    logic [9:0] seen;
    logic [16:0] rd;
    logic q, pwr;
    int n;
    host.frame(code, seen);
    chk("ack", 16'h0001, seen);
    chk("channel", chan, adc_channel);
    host.ack2(q);
    chk("busy", 16'h0001, q);
    pwr = 1'b0;
    n = 0;
    while (dout === 1'b1 && n < 9000)
    begin
      @(posedge clk);
      #5;
      n++;
      pwr = pwr | sensor_power;
    end
    if (n >= 9000)
    begin
      failures++;
      summarize();
    end
    chk("power", 16'h0001, pwr);
    chk("power off", 16'h0000, sensor_power);
    chk("paced", 16'h0001, n > 2100);
    host.read17(pause, rd);
    chk("result", w, rd[16:1]);
    chk("tail", 16'h0000, rd[0]);
  endtask : conv

  task automatic cal(input logic [3:0] code, input logic [15:0] w);
    logic [9:0] seen;
    logic [16:0] rd;
    host.frame(code, seen);
    chk("cal frame", 16'h0000, seen);
    host.read17(1'b0, rd);
    chk("cal word", w, rd[16:1]);
    chk("cal tail", 16'h0000, rd[0]);
  endtask : cal

  task automatic t_after_reset();
    host.wclk(2);
    chk("dout", 16'h0000, dout);
    chk("power", 16'h0000, sensor_power);
    chk("ready", 16'h0001, adc_ready);
    host.sendrst();
    host.wclk(10);
    chk("dout idle", 16'h0000, dout);
  endtask : t_after_reset

  task automatic t_pressure();
    push(16'hA5C3);
    adc_valid = 1'b0;
    conv(psr_pkg::CODE_PRESS, 1'b0, 16'hA5C3, 1'b1);
  endtask : t_pressure

  task automatic t_temp();
    push(16'h5A3C);
    adc_valid = 1'b0;
    conv(psr_pkg::CODE_TEMP, 1'b1, 16'h5A3C, 1'b0);
  endtask : t_temp

  task automatic t_cal();
    mclk_run = 1'b0;
    cal(psr_pkg::CODE_CAL1, W1);
    cal(psr_pkg::CODE_CAL2, W2);
    cal(psr_pkg::CODE_CAL3, W3);
    cal(psr_pkg::CODE_CAL4, W4);
    mclk_run = 1'b1;
  endtask : t_cal

  task automatic t_bad_code();
    logic [9:0] seen;
    host.frame(4'hF, seen);
    chk("bad frame", 16'h0000, seen);
    cal(psr_pkg::CODE_CAL2, W2);
  endtask : t_bad_code

  task automatic t_reset_conv();
    logic [9:0] seen;
    logic q;
    host.frame(psr_pkg::CODE_PRESS, seen);
    host.ack2(q);
    host.wclk(100);
    chk("conv busy", 16'h0001, dout);
    host.sendrst();
    host.wclk(10);
    chk("dout idle", 16'h0000, dout);
    cal(psr_pkg::CODE_CAL4, W4);
  endtask : t_reset_conv

  // Fill until refused, then drain one word per conversion
  task automatic t_fifo();
    for (int i = 0; i < 16; i++)
    begin
      push(16'h1000 + 16'(i));
    end
    chk("full", 16'h0000, adc_ready);
    adc_data = 16'hDEAD;
    host.wclk(5);
    chk("still full", 16'h0000, adc_ready);
    adc_valid = 1'b0;
    for (int i = 0; i < 16; i++)
    begin
      conv(i[0] ? psr_pkg::CODE_TEMP : psr_pkg::CODE_PRESS, i[0],
        16'h1000 + 16'(i), 1'b0);
    end
    push(16'h7777);
    adc_valid = 1'b0;
    conv(psr_pkg::CODE_PRESS, 1'b0, 16'h7777, 1'b0);
  endtask : t_fifo

  initial
  begin
    clk = 1'b0;
    mclk = 1'b0;
    mclk_run = 1'b1;
    nrst = 1'b0;
    adc_valid = 1'b0;
    adc_data = 16'h0000;
    failures = 0;
    n_compared = 0;
    repeat (10) @(posedge clk);
    #5;
    nrst = 1'b1;
    t_after_reset();
    t_pressure();
    t_temp();
    t_cal();
    t_bad_code();
    t_reset_conv();
    t_fifo();
    summarize();
  end
endmodule : test_pressure_sensor_serial_readout

`default_nettype wire
